// ==== logic/adc_ctrl_pkg.sv ====
// Constants, register map and state types of the converter control block
package adc_ctrl_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] CONV_CONTROL_STATUS_OFS  = 8'h00;
  localparam logic [7:0] CONV_CONTROL_B_OFS       = 8'h04;
  localparam logic [7:0] CHANNEL_MUX_REGISTER_OFS = 8'h08;
  localparam logic [7:0] COMPARE_STATUS_OFS       = 8'h0C;
  localparam logic [7:0] ANALOG_MISC_CONTROL_OFS  = 8'h10;
  localparam logic [7:0] CONV_RESULT_OFS          = 8'h14;

  // conv_control_status fields
  localparam int CONVERTER_ENABLE_BIT = 7;
  localparam int CONV_START_BIT       = 6;
  localparam int AUTO_TRIGGER_BIT     = 5;
  localparam int CONV_DONE_FLAG_BIT   = 4;
  localparam int DIV_SEL_LSB          = 0;

  // conv_control_b fields
  localparam int COMPARE_MUX_EN_BIT = 6;
  localparam int REF_DIV_LSB        = 4;
  localparam int TRIG_SRC_LSB       = 0;

  // channel_mux_register fields
  localparam int REF_SRC_LSB = 6;
  localparam int CHAN_LSB    = 0;

  // compare_status_register fields
  localparam int DIV_REF_SEL_BIT    = 6;
  localparam int COMPARE_RESULT_BIT = 5;
  localparam int COMPARE_FLAG_BIT   = 4;
  localparam int COMPARE_IE_BIT     = 3;
  localparam int EDGE_MODE_LSB      = 0;

  // analog_misc_control fields
  localparam int EXT_REF_IN_EN_BIT = 2;
  localparam int INT_REF_OUT_EN_BIT = 1;

  // Trigger source code for self retriggering
  localparam logic [2:0] TRIG_FREE_RUN = 3'h0;

  // Comparator edge modes
  localparam logic [1:0] EDGE_TOGGLE = 2'h0;
  localparam logic [1:0] EDGE_FALL   = 2'h2;
  localparam logic [1:0] EDGE_RISE   = 2'h3;

  // Highest positive mux channel code and reference code for divided ref
  localparam logic [4:0] CHAN_MAX      = 5'h0A;
  localparam logic [1:0] REF_SRC_2V56  = 2'h3;

  // Conversion lengths in converter clock cycles
  localparam logic [4:0] NORMAL_CONV_CYCLES = 5'd13;
  localparam logic [4:0] FIRST_CONV_CYCLES  = 5'd25;

  // Reset values
  localparam logic [7:0]  REG_RESET    = 8'h00;
  localparam logic [9:0]  RESULT_RESET = 10'h000;
  localparam logic [31:0] BUS_ZERO     = 32'h0000_0000;

  typedef enum logic [1:0] { CONV_IDLE, CONV_WAIT, CONV_RUN } conv_state_t;

  typedef struct packed {
    logic        convEnable;
    logic        autoTrigger;
    logic        doneFlag;
    logic [2:0]  divSel;
    logic        compareMuxEnable;
    logic [1:0]  refDivide;
    logic [2:0]  trigSrc;
    logic [1:0]  refSource;
    logic [4:0]  channelSel;
    logic        divRefSelect;
    logic        compareFlag;
    logic        compareIe;
    logic [1:0]  edgeMode;
    logic        extRefEn;
    logic        refOutEn;
    logic [9:0]  result;
    conv_state_t convState;
    logic        firstConv;
    logic [4:0]  cycleCnt;
    logic [6:0]  prescCnt;
    logic        cmpSync1;
    logic        cmpSync2;
    logic        cmpLast;
    logic        trgSync1;
    logic        trgSync2;
    logic        trgLast;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        startPulse;
    logic        compareIrq;
    logic        posUseMux;
  } state_t;

endpackage : adc_ctrl_pkg

// ==== logic/adc_ctrl.sv ====
// Converter sequencing, reference and comparator mux control with APB
// Behaviour
// - Done flag trigger restarts conversion at once
// - Free running ignores done flag clearing
// - Start bit write works under auto trigger
// - Start bit reads one while converting
// - Prescaler runs on enable, reset otherwise
// - Start waits for next converter clock edge
// - Normal conversion takes 13 converter clocks
// - First conversion after enable takes 25
// - Misc bit 2 selects external reference
// - Misc bit 1 drives reference output
// - Comparator flag on rise, fall or toggle
// - Mux enabled, converter off, channel up to ten: channel picks input
// - Otherwise positive pin feeds comparator
// - Divided reference select replaces negative pin
// - Divide codes give full, half, quarter, eighth
`timescale 1ns/1ns
module adc_ctrl
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Analog side inputs (asynchronous pins)
  input  wire logic        compareResultPin,
  input  wire logic        triggerPin,
  // Digitised sample from the successive approximation core
  input  wire logic [9:0]  sampleValue,
  // Analog side controls
  output logic             sampleStart,
  output logic             convBusy,
  output logic             posUseMux,
  output logic [4:0]       posChannel,
  output logic             negUseDivRef,
  output logic [1:0]       divRefCode,
  output logic             divRefValid,
  output logic             extRefInEnable,
  output logic             refOutEnable,
  output logic             compareIrq
);

  state_t q;
  state_t d;

  // Bus decode, converter timing and edge helpers
  logic       access;
  logic       wrEn;
  logic       mapped;
  logic [7:0] wb;
  logic [6:0] divMask;
  logic       convTick;
  logic       cmpRise;
  logic       cmpFall;
  logic       cmpEvent;
  logic       trgRise;
  logic       finish;
  logic       retrigger;
  logic       swStart;
  logic       hwStart;
  logic [4:0] convLen;
  logic [7:0] rdByte;

  assign access = psel & penable;
  assign wb     = pwdata[7:0];
  assign mapped = (paddr == CONV_CONTROL_STATUS_OFS)
                | (paddr == CONV_CONTROL_B_OFS)
                | (paddr == CHANNEL_MUX_REGISTER_OFS)
                | (paddr == COMPARE_STATUS_OFS)
                | (paddr == ANALOG_MISC_CONTROL_OFS)
                | (paddr == CONV_RESULT_OFS);
  // Write lands on the edge where the master sees pready high
  assign wrEn   = access & pwrite & q.pready & mapped;

  // Divide ratio 2^sel, with sel 0 also dividing by two
  always_comb
  begin
    divMask = 7'h00;
    case (q.divSel)
      3'h0, 3'h1: divMask = 7'h01;
      3'h2:       divMask = 7'h03;
      3'h3:       divMask = 7'h07;
      3'h4:       divMask = 7'h0F;
      3'h5:       divMask = 7'h1F;
      3'h6:       divMask = 7'h3F;
      default:    divMask = 7'h7F;
    endcase
  end

  // One tick per rising edge of the divided converter clock
  assign convTick = q.convEnable & ((q.prescCnt & divMask) == divMask);

  // Edges from synchronised comparator and trigger pins
  assign cmpRise  = q.cmpSync2 & ~q.cmpLast;
  assign cmpFall  = ~q.cmpSync2 & q.cmpLast;
  assign trgRise  = q.trgSync2 & ~q.trgLast;

  always_comb
  begin
    cmpEvent = 1'b0;
    case (q.edgeMode)
      EDGE_TOGGLE: cmpEvent = cmpRise | cmpFall;
      EDGE_FALL:   cmpEvent = cmpFall;
      EDGE_RISE:   cmpEvent = cmpRise;
      default:     cmpEvent = 1'b0;
    endcase
  end

  assign convLen = q.firstConv ? FIRST_CONV_CYCLES
                               : NORMAL_CONV_CYCLES;
  assign finish  = (q.convState == CONV_RUN) & convTick
                 & (q.cycleCnt == convLen - 5'd1);
  // Free running follows completion only, never the flag's state
  assign retrigger = finish & q.autoTrigger
                   & (q.trigSrc == TRIG_FREE_RUN);
  assign swStart = wrEn & (paddr == CONV_CONTROL_STATUS_OFS)
                 & wb[CONV_START_BIT] & wb[CONVERTER_ENABLE_BIT];
  assign hwStart = trgRise & q.autoTrigger & q.convEnable
                 & (q.trigSrc != TRIG_FREE_RUN);

  // Read mux for the byte registers
  always_comb
  begin
    rdByte = REG_RESET;
    case (paddr)
      CONV_CONTROL_STATUS_OFS:
      begin
        rdByte[CONVERTER_ENABLE_BIT] = q.convEnable;
        rdByte[CONV_START_BIT] = (q.convState != CONV_IDLE);
        rdByte[AUTO_TRIGGER_BIT] = q.autoTrigger;
        rdByte[CONV_DONE_FLAG_BIT] = q.doneFlag;
        rdByte[DIV_SEL_LSB +: 3] = q.divSel;
      end
      CONV_CONTROL_B_OFS:
      begin
        rdByte[COMPARE_MUX_EN_BIT] = q.compareMuxEnable;
        rdByte[REF_DIV_LSB +: 2] = q.refDivide;
        rdByte[TRIG_SRC_LSB +: 3] = q.trigSrc;
      end
      CHANNEL_MUX_REGISTER_OFS:
      begin
        rdByte[REF_SRC_LSB +: 2] = q.refSource;
        rdByte[CHAN_LSB +: 5] = q.channelSel;
      end
      COMPARE_STATUS_OFS:
      begin
        rdByte[DIV_REF_SEL_BIT] = q.divRefSelect;
        rdByte[COMPARE_RESULT_BIT] = q.cmpSync2;
        rdByte[COMPARE_FLAG_BIT] = q.compareFlag;
        rdByte[COMPARE_IE_BIT] = q.compareIe;
        rdByte[EDGE_MODE_LSB +: 2] = q.edgeMode;
      end
      ANALOG_MISC_CONTROL_OFS:
      begin
        // Reserved bits 7:3 read as zero
        rdByte[EXT_REF_IN_EN_BIT] = q.extRefEn;
        rdByte[INT_REF_OUT_EN_BIT] = q.refOutEn;
      end
      default: rdByte = REG_RESET;
    endcase
  end

  // Next state of the whole block
  always_comb
  begin
    d = q;
    d.startPulse = 1'b0;

    // Two flops on every pin before any logic looks at it
    d.cmpSync1 = compareResultPin;
    d.cmpSync2 = q.cmpSync1;
    d.cmpLast  = q.cmpSync2;
    d.trgSync1 = triggerPin;
    d.trgSync2 = q.trgSync1;
    d.trgLast  = q.trgSync2;

    // APB: one wait state, then answer with registered data
    d.pready  = access & ~q.pready;
    d.pslverr = access & ~q.pready & ~mapped;
    d.prdata  = BUS_ZERO;
    if (access & ~q.pready & ~pwrite & mapped)
    begin
      if (paddr == CONV_RESULT_OFS)
        d.prdata = {22'h000000, q.result};
      else
        d.prdata = {24'h000000, rdByte};
    end

    // Register writes
    if (wrEn)
    begin
      case (paddr)
        CONV_CONTROL_STATUS_OFS:
        begin
          d.convEnable = wb[CONVERTER_ENABLE_BIT];
          d.autoTrigger = wb[AUTO_TRIGGER_BIT];
          d.divSel = wb[DIV_SEL_LSB +: 3];
          if (wb[CONV_DONE_FLAG_BIT])
            d.doneFlag = 1'b0; // Write one clears
        end
        CONV_CONTROL_B_OFS:
        begin
          d.compareMuxEnable = wb[COMPARE_MUX_EN_BIT];
          d.refDivide = wb[REF_DIV_LSB +: 2];
          d.trigSrc = wb[TRIG_SRC_LSB +: 3];
        end
        CHANNEL_MUX_REGISTER_OFS:
        begin
          d.refSource = wb[REF_SRC_LSB +: 2];
          d.channelSel = wb[CHAN_LSB +: 5];
        end
        COMPARE_STATUS_OFS:
        begin
          d.divRefSelect = wb[DIV_REF_SEL_BIT];
          d.compareIe = wb[COMPARE_IE_BIT];
          d.edgeMode = wb[EDGE_MODE_LSB +: 2];
          if (wb[COMPARE_FLAG_BIT])
            d.compareFlag = 1'b0; // Write one clears
        end
        ANALOG_MISC_CONTROL_OFS:
        begin
          d.extRefEn = wb[EXT_REF_IN_EN_BIT];
          d.refOutEn = wb[INT_REF_OUT_EN_BIT];
        end
        default: d.convEnable = q.convEnable;
      endcase
    end

    // Comparator event after the clear so a new edge is never lost
    if (cmpEvent)
      d.compareFlag = 1'b1;
    d.compareIrq = d.compareFlag & d.compareIe;

    // Prescaler held at zero while the converter is off
    if (q.convEnable)
      d.prescCnt = q.prescCnt + 7'd1;
    else
      d.prescCnt = 7'h00;

    // Conversion sequencer
    case (q.convState)
      CONV_IDLE:
      begin
        d.cycleCnt = 5'd0;
        if (swStart | hwStart)
          d.convState = CONV_WAIT;
      end
      CONV_WAIT:
      begin
        // Begins on the next divided clock edge
        if (convTick)
        begin
          d.convState = CONV_RUN;
          d.cycleCnt = 5'd0;
          d.startPulse = 1'b1;
        end
      end
      CONV_RUN:
      begin
        if (convTick)
          d.cycleCnt = q.cycleCnt + 5'd1;
        if (finish)
        begin
          d.result = sampleValue;
          d.doneFlag = 1'b1;
          d.firstConv = 1'b0;
          d.cycleCnt = 5'd0;
          // Free running restarts on this very tick, busy never drops
          d.convState = retrigger ? CONV_RUN : CONV_IDLE;
          d.startPulse = retrigger;
        end
      end
      default: d.convState = CONV_IDLE;
    endcase

    // Switching off aborts any conversion and rearms the long first one
    if (~d.convEnable)
    begin
      d.convState = CONV_IDLE;
      d.firstConv = 1'b1;
      d.cycleCnt = 5'd0;
      d.startPulse = 1'b0; // No start pulse on the disabling tick
    end
  end

  // State register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.convState <= CONV_IDLE;
      q.firstConv <= 1'b1;
    end
    else
      q <= d;
  end

  // Mux and reference controls, registered for glitch free switching
  logic       posMuxQ;
  logic [4:0] posChanQ;
  logic       negDivQ;
  logic [1:0] divCodeQ;
  logic       divValidQ;
  logic       extRefQ;
  logic       refOutQ;
  logic       busyQ;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      posMuxQ   <= 1'b0;
      posChanQ  <= 5'h00;
      negDivQ   <= 1'b0;
      divCodeQ  <= 2'h0;
      divValidQ <= 1'b0;
      extRefQ   <= 1'b0;
      refOutQ   <= 1'b0;
      busyQ     <= 1'b0;
    end
    else
    begin
      // Channel codes above ten leave the pin on the input
      posMuxQ   <= d.compareMuxEnable & ~d.convEnable
                 & (d.channelSel <= CHAN_MAX);
      posChanQ  <= d.channelSel;
      negDivQ   <= d.divRefSelect;
      divCodeQ  <= d.refDivide;
      // Other reference sources are reserved for the divided ref
      divValidQ <= d.divRefSelect
                 & (d.refSource == REF_SRC_2V56);
      extRefQ   <= d.extRefEn;
      refOutQ   <= d.refOutEn;
      busyQ     <= (d.convState != CONV_IDLE);
    end
  end

  // Outputs straight from flops
  assign pready         = q.pready;
  assign pslverr        = q.pslverr;
  assign prdata         = q.prdata;
  assign sampleStart    = q.startPulse;
  assign compareIrq     = q.compareIrq;
  assign posUseMux      = posMuxQ;
  assign posChannel     = posChanQ;
  assign negUseDivRef   = negDivQ;
  assign divRefCode     = divCodeQ;
  assign divRefValid    = divValidQ;
  assign extRefInEnable = extRefQ;
  assign refOutEnable   = refOutQ;
  assign convBusy       = busyQ;

endmodule : adc_ctrl

// ==== sim/adc_ctrl_assertions.sv ====
// Port level checks of the converter control block
`timescale 1ns/1ns
module adc_ctrl_assertions
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // Analog side controls
  input wire logic        sampleStart,
  input wire logic        convBusy,
  input wire logic        posUseMux,
  input wire logic [4:0]  posChannel,
  input wire logic        negUseDivRef,
  input wire logic        divRefValid,
  input wire logic        extRefInEnable,
  input wire logic        refOutEnable,
  input wire logic        compareIrq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // Completed write to the misc register
  wire wrMisc = psel && penable && pwrite && pready &&
                paddr == ANALOG_MISC_CONTROL_OFS;

  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("Late APB answer");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("Error without ready");
  property p_idle; !pready |-> prdata == BUS_ZERO; endproperty
  a_idle: assert property (p_idle) else $error("Read data outside answer");
  property p_chan; posUseMux |-> posChannel <= CHAN_MAX; endproperty
  a_chan: assert property (p_chan) else $error("Mux on reserved code");
  property p_mux; sampleStart |-> !posUseMux; endproperty
  a_mux: assert property (p_mux) else $error("Mux used while on");
  property p_div; divRefValid |-> negUseDivRef; endproperty
  a_div: assert property (p_div) else $error("Divided ref unselected");
  // Even the fastest divider keeps a conversion busy well past 8 cycles
  property p_hold; sampleStart |=> convBusy [*8]; endproperty
  a_hold: assert property (p_hold) else $error("Conversion too short");
  property p_start; $rose(convBusy) |-> ##[0:130] sampleStart; endproperty
  a_start: assert property (p_start) else $error("Start not on tick");
  property p_ext; $changed(extRefInEnable) |-> $past(wrMisc); endproperty
  a_ext: assert property (p_ext) else $error("Ext ref moved alone");
  property p_refo;
    $past(wrMisc) |-> refOutEnable == $past(pwdata[INT_REF_OUT_EN_BIT]);
  endproperty
  a_refo: assert property (p_refo) else $error("Ref output wrong");

  // Main scenarios reached
  c_conv: cover property (sampleStart);
  c_irq: cover property ($rose(compareIrq));
  c_err: cover property (pslverr);
endmodule : adc_ctrl_assertions

bind adc_ctrl adc_ctrl_assertions adc_ctrl_assertions_inst (
  .clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .prdata, .sampleStart, .convBusy, .posUseMux, .posChannel,
  .negUseDivRef, .divRefValid, .extRefInEnable, .refOutEnable, .compareIrq
);

// ==== sim/analog_side_model.sv ====
// Analog side stand-in: comparator, trigger pin and sample codes
`timescale 1ns/1ns
module analog_side_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Bench levels and converter pulse
  input  wire logic       cmpLevel,
  input  wire logic       trigLevel,
  input  wire logic       sampleStart,
  // Pins towards the block
  output logic            compareResultPin,
  output logic            triggerPin,
  output logic [9:0]      sampleValue
);
  // Fresh code per conversion, so a stale result shows up
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n) sampleValue <= 10'h000;
    else if (sampleStart) sampleValue <= sampleValue + 10'h001;
  // Comparator and trigger follow the bench levels
  assign compareResultPin = cmpLevel;
  assign triggerPin       = trigLevel;
endmodule : analog_side_model

// ==== sim/tb_adc_ctrl.sv ====
// Self-checking bench of the converter control block
`timescale 1ns/1ns
module tb_adc_ctrl
  import adc_ctrl_pkg::*;
;
  logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        cmpLevel, trigLevel, compareResultPin, triggerPin;
  logic        sampleStart, convBusy, posUseMux, negUseDivRef;
  logic        divRefValid, extRefInEnable, refOutEnable, compareIrq;
  logic [4:0]  posChannel;
  logic [1:0]  divRefCode;
  logic [9:0]  sampleValue;
  int          miscompares, n_compared, m1, m2, k;

  adc_ctrl adc_ctrl_inst (.clock, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .prdata, .compareResultPin,
    .triggerPin, .sampleValue, .sampleStart, .convBusy, .posUseMux,
    .posChannel, .negUseDivRef, .divRefCode, .divRefValid,
    .extRefInEnable, .refOutEnable, .compareIrq);
  analog_side_model analog_side_model_inst (.clock, .rst_n, .cmpLevel,
    .trigLevel, .sampleStart, .compareResultPin, .triggerPin,
    .sampleValue);

  // 50 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk

  // One APB transfer; an idle cycle follows so strobes never collide
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clock);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      miscompares++;
      give_verdict();
    end
    @(posedge clock);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask : rdc

  // Bounded wait for a conversion to begin
  task automatic waitStart;
    int i;
    for (i = 0; i < 3000 && sampleStart !== 1'b1; i++) @(posedge clock);
    if (sampleStart !== 1'b1)
    begin
      miscompares++;
      give_verdict();
    end
  endtask : waitStart

  task automatic measure(output int n);
    waitStart();
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end while (convBusy === 1'b1 && n < 3000);
    if (convBusy === 1'b1)
    begin
      miscompares++;
      give_verdict();
    end
  endtask : measure

  task automatic cnt(input int n, output int c);
    c = 0;
    repeat (n)
    begin
      @(posedge clock);
      if (sampleStart === 1'b1) c++;
    end
  endtask : cnt

  // Clear the flag, set the mode, then move the comparator
  task automatic edgeTry(input logic [1:0] m, input logic ie,
                         input logic lvl, input logic e);
    wr(COMPARE_STATUS_OFS, {24'h00, 4'h5, ie, 1'b0, m});
    cmpLevel <= lvl;
    repeat (8) @(posedge clock);
    chk(compareIrq, e);
  endtask : edgeTry

  // Main sequence
  initial
  begin
    {rst_n, psel, penable, pwrite, cmpLevel, trigLevel} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    miscompares = 0;
    n_compared = 0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rdc(ANALOG_MISC_CONTROL_OFS, 32'h0000_0000);
    rdc(CONV_CONTROL_STATUS_OFS, 32'h0000_0000);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({31'h0000_0000, er}, 32'h0000_0001);
    wr(ANALOG_MISC_CONTROL_OFS, 32'h06);
    chk({extRefInEnable, refOutEnable}, 2'h3);
    rdc(ANALOG_MISC_CONTROL_OFS, 32'h06);
    wr(CONV_CONTROL_B_OFS, 32'h60);
    wr(COMPARE_STATUS_OFS, 32'h40);
    wr(CHANNEL_MUX_REGISTER_OFS, 32'hCA);
    chk({posUseMux, posChannel}, {1'b1, CHAN_MAX});
    chk({negUseDivRef, divRefValid, divRefCode}, 4'hE);
    wr(CHANNEL_MUX_REGISTER_OFS, 32'hCB);
    chk(posUseMux, 1'b0);
    wr(CHANNEL_MUX_REGISTER_OFS, 32'h4A);
    chk({posUseMux, divRefValid}, 2'h2);
    // First conversion after enable, then a normal one
    wr(CONV_CONTROL_STATUS_OFS, 32'hC0);
    measure(m1);
    rdc(CONV_CONTROL_STATUS_OFS, 32'h90);
    rdc(CONV_RESULT_OFS, 32'h1);
    wr(CONV_CONTROL_STATUS_OFS, 32'hD0);
    measure(m2);
    chk(m1 - m2, 24);
    chk(m2 > 24 && m2 < 28, 1'b1);
    // Slowest divider, the nearest this clock gets to the low range
    wr(CONV_CONTROL_STATUS_OFS, 32'hD7);
    measure(m2);
    chk(m2, 13 * 128);
    wr(CONV_CONTROL_STATUS_OFS, 32'hD0);
    waitStart();
    chk(posUseMux, 1'b0);
    rdc(CONV_CONTROL_STATUS_OFS, 32'hC0);
    // Free running; the done flag is left set on purpose
    wr(CONV_CONTROL_STATUS_OFS, 32'hF0);
    // Back to back 13 tick conversions of 2 cycles: one per 26 cycles
    cnt(300, k);
    chk(k >= 11 && k <= 12, 1'b1);
    cnt(300, k);
    chk(k >= 11 && k <= 12, 1'b1);
    waitStart();
    repeat (12) @(posedge clock);
    wr(CONV_CONTROL_STATUS_OFS, 32'h00);
    chk(posUseMux, 1'b1);
    // Single start under auto trigger, then one pin trigger
    wr(CONV_CONTROL_B_OFS, 32'h61);
    wr(CONV_CONTROL_STATUS_OFS, 32'hA0);
    wr(CONV_CONTROL_STATUS_OFS, 32'hE0);
    cnt(200, k);
    chk(k, 1);
    trigLevel <= 1'b1;
    cnt(200, k);
    chk(k, 1);
    trigLevel <= 1'b0;
    wr(CONV_CONTROL_STATUS_OFS, 32'h00);
    // Every edge mode against a rise and a fall, then masked
    for (k = 0; k < 4; k++)
    begin
      edgeTry(k[1:0], 1'b1, 1'b1, k == 0 || k == 3);
      edgeTry(k[1:0], 1'b1, 1'b0, k == 0 || k == 2);
    end
    edgeTry(EDGE_RISE, 1'b0, 1'b1, 1'b0);
    give_verdict();
  end
endmodule : tb_adc_ctrl
